// ---- design/sbsc_pkg.sv ----
package sbsc_pkg;
    localparam int ADDR_W = 18;
    localparam int LANE_CNT = 4;
    localparam int LANE_W = 8;
    localparam int WORD_LANE_W = LANE_W + 1;
    localparam int DATA_W = LANE_CNT * LANE_W;
    localparam int WORD_W = LANE_CNT * WORD_LANE_W;
    localparam int CNT_W = 2;
    localparam int WIDE_LANES = 2;
    localparam int MEM_DEPTH = 1 << ADDR_W;

    // Build width: 1 for the four-lane (32/36-bit) configuration
    localparam logic WIDE_CFG = 1'b1;

    // Positions in the floating-pin vector
    localparam int MODE_CNT = 5;
    localparam int MF_FT = 0;
    localparam int MF_SCD = 1;
    localparam int MF_ZQ = 2;
    localparam int MF_ZZ = 3;
    localparam int MF_PE = 4;

    // Levels seen on an unconnected mode pin
    localparam logic DFLT_FT = 1'b1;
    localparam logic DFLT_SCD = 1'b1;
    localparam logic DFLT_ZQ = 1'b1;
    localparam logic DFLT_ZZ = 1'b0;
    localparam logic DFLT_PE = 1'b0;

    localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
    localparam logic [LANE_CNT-1:0] LANES_ALL = 4'hF;
    localparam logic [LANE_CNT-1:0] LANES_NONE = 4'h0;
    localparam logic [LANE_CNT-1:0] LANES_NARROW = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [WORD_W-1:0] WORD_RST = 36'h0_0000_0000;

    typedef enum logic [4:0] {
        CMD_DESEL = 5'h01,
        CMD_LOAD_RD = 5'h02,
        CMD_LOAD_WR = 5'h04,
        CMD_STEP = 5'h08,
        CMD_HOLD = 5'h10
    } sbsc_cmd_t;

    typedef enum logic [3:0] {
        OP_IDLE = 4'h1,
        OP_READ = 4'h2,
        OP_WRITE = 4'h4,
        OP_DESEL = 4'h8
    } sbsc_op_t;

    function automatic logic [CNT_W-1:0] burst_low(input logic [CNT_W-1:0] start,
                                                   input logic [CNT_W-1:0] cnt,
                                                   input logic linear);
        burst_low = linear ? CNT_W'(start + cnt) : (start ^ cnt);
    endfunction : burst_low

    function automatic logic mode_pin(input logic floating, input logic level,
                                      input logic dflt);
        mode_pin = floating ? dflt : level;
    endfunction : mode_pin
endpackage : sbsc_pkg

// ---- design/sbsc_mem.sv ----
`timescale 1ns/1ps
module sbsc_mem
    import sbsc_pkg::*;
(
    input wire logic i_sys_clk, // System clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic [sbsc_pkg::ADDR_W-1:0] i_addr, // Word address
    input wire logic [sbsc_pkg::LANE_CNT-1:0] i_lane_we, // Per-lane write strobe
    input wire logic [sbsc_pkg::WORD_W-1:0] i_wdata, // Write word
    output logic [sbsc_pkg::WORD_W-1:0] o_rdata // Registered read word
);
    logic [WORD_W-1:0] mem [MEM_DEPTH];

    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < LANE_CNT; i++) begin
            if (i_lane_we[i]) begin
                mem[i_addr][i*WORD_LANE_W +: WORD_LANE_W] <= i_wdata[i*WORD_LANE_W +: WORD_LANE_W];
            end
        end
    end

    // Read-before-write; a write cycle never drives the pins anyway
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= WORD_RST;
        end else begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule : sbsc_mem

// ---- design/sbsc_ctrl.sv ----
// Operation
// - Two-bit burst counter, linear or interleaved order
// - Floating flow, deselect, drive pins default high
// - Floating sleep, parity-lane pins default low
// - Both write strobes high: read, all lanes
// - Global write all lanes; byte write selected
// - All data lanes high impedance while writing
// - Upper two lanes written only in wide build; reads drive all four
// - Partial enable with controller strobe, or processor strobe with select 1 true, gives deselect
// - Enabled processor strobe loads, begins read
// - Controller strobe loads, read or write
// - Advance low steps to next burst address
// - Advance high repeats the current address
// - Output enable gates drivers asynchronously
// - Dummy read advances counter like read
// - Enabled only when all three selects true
`timescale 1ns/1ps
module sbsc_ctrl
    import sbsc_pkg::*;
(
    input wire logic i_sys_clk, // 10 MHz clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic [sbsc_pkg::ADDR_W-1:0] i_addr, // External address
    input wire logic [sbsc_pkg::DATA_W-1:0] i_dq, // Data pins, input side
    output logic [sbsc_pkg::DATA_W-1:0] o_dq, // Data pins, output side
    output logic [sbsc_pkg::LANE_CNT-1:0] o_dq_oe, // Per-lane drive enable
    input wire logic [sbsc_pkg::LANE_CNT-1:0] i_parity_lanes, // Ninth bits, input
    output logic [sbsc_pkg::LANE_CNT-1:0] o_parity_lanes, // Ninth bits, output
    output logic [sbsc_pkg::LANE_CNT-1:0] o_parity_lanes_oe, // Ninth bit drive enable
    input wire logic i_chip_sel1_n, // Chip select 1, active low
    input wire logic i_chip_sel2, // Chip select 2, active high
    input wire logic i_chip_sel3_n, // Chip select 3, active low
    input wire logic i_cpu_addr_strobe_n, // Processor address strobe
    input wire logic i_cache_ctrl_addr_strobe_n, // Controller address strobe
    input wire logic i_burst_step_n, // Burst advance, active low
    input wire logic i_global_write_n, // Write all lanes
    input wire logic i_byte_write_n, // Write selected lanes
    input wire logic i_lane0_write_n, // Lane 0 write select
    input wire logic i_lane1_write_n, // Lane 1 write select
    input wire logic i_lane2_write_n, // Lane 2 write select
    input wire logic i_lane3_write_n, // Lane 3 write select
    input wire logic i_out_enable_n, // Output enable, asynchronous
    input wire logic i_burst_order_select_n, // Low linear, high interleaved
    input wire logic i_flow_through_select_n, // Low flow-through
    input wire logic i_deselect_depth_select, // Low dual-cycle deselect
    input wire logic i_drive_strength_select, // Low high drive
    input wire logic i_sleep_request, // High standby, asynchronous
    input wire logic i_parity_lane_enable_n, // Low ninth bits active
    input wire logic [sbsc_pkg::MODE_CNT-1:0] i_mode_float, // Mode pin left open
    output logic o_high_drive, // Strong output drivers chosen
    output logic o_standby // Sleep in force
);
    import sbsc_pkg::*;

    logic pipe_mode;
    logic single_desel;
    logic sleep;
    logic parity_on;
    logic linear;
    logic chip_en;
    logic wr_dec;
    logic [LANE_CNT-1:0] lane_sel;
    sbsc_cmd_t cmd;
    logic [ADDR_W-1:0] base_addr;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] next_base;
    logic [CNT_W-1:0] next_cnt;
    logic [ADDR_W-1:0] mem_addr;
    logic [LANE_CNT-1:0] mem_we;
    logic [WORD_W-1:0] mem_wdata;
    logic [WORD_W-1:0] mem_rdata;
    logic [WORD_W-1:0] pipe_word;
    logic [WORD_W-1:0] out_word;
    sbsc_op_t op_q;
    logic rd_q2;
    logic drive;

    // Mode pins: open pins fall to their pull levels
    always_comb begin
        pipe_mode = mode_pin(i_mode_float[MF_FT], i_flow_through_select_n, DFLT_FT);
        single_desel = mode_pin(i_mode_float[MF_SCD], i_deselect_depth_select, DFLT_SCD);
        o_high_drive = !mode_pin(i_mode_float[MF_ZQ], i_drive_strength_select, DFLT_ZQ);
        sleep = mode_pin(i_mode_float[MF_ZZ], i_sleep_request, DFLT_ZZ);
        parity_on = !mode_pin(i_mode_float[MF_PE], i_parity_lane_enable_n, DFLT_PE);
    end

    assign o_standby = sleep;
    assign linear = !i_burst_order_select_n;
    assign chip_en = !i_chip_sel1_n && i_chip_sel2 && !i_chip_sel3_n;
    assign wr_dec = !i_global_write_n || !i_byte_write_n;

    always_comb begin
        if (!i_global_write_n) begin
            lane_sel = LANES_ALL;
        end else if (!i_byte_write_n) begin
            lane_sel = ~{i_lane3_write_n, i_lane2_write_n, i_lane1_write_n, i_lane0_write_n};
        end else begin
            lane_sel = LANES_NONE;
        end
        if (!WIDE_CFG) begin
            lane_sel = lane_sel & LANES_NARROW;
        end
    end

    // Sleep is treated as a deselect so no array access starts in standby
    always_comb begin
        if (sleep) begin
            cmd = CMD_DESEL;
        end else if (!i_cpu_addr_strobe_n && !i_chip_sel1_n) begin
            cmd = chip_en ? CMD_LOAD_RD : CMD_DESEL;
        end else if (!i_cache_ctrl_addr_strobe_n) begin
            if (!chip_en) begin
                cmd = CMD_DESEL;
            end else begin
                cmd = wr_dec ? CMD_LOAD_WR : CMD_LOAD_RD;
            end
        end else begin
            cmd = i_burst_step_n ? CMD_HOLD : CMD_STEP;
        end
    end

    // Counter ignores output enable, so dummy reads advance it too
    always_comb begin
        case (cmd)
            CMD_LOAD_RD, CMD_LOAD_WR: begin
                next_base = i_addr;
                next_cnt = CNT_ZERO;
            end
            CMD_STEP: begin
                next_base = base_addr;
                next_cnt = CNT_W'(cnt + CNT_ONE);
            end
            default: begin
                next_base = base_addr;
                next_cnt = cnt;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            base_addr <= ADDR_RST;
            cnt <= CNT_ZERO;
        end else begin
            base_addr <= next_base;
            cnt <= next_cnt;
        end
    end

    assign mem_addr = {next_base[ADDR_W-1:CNT_W], burst_low(next_base[CNT_W-1:0], next_cnt, linear)};

    always_comb begin
        mem_we = LANES_NONE;
        if (cmd == CMD_LOAD_WR || ((cmd == CMD_STEP || cmd == CMD_HOLD) && wr_dec)) begin
            mem_we = lane_sel;
        end
        for (int i = 0; i < LANE_CNT; i++) begin
            mem_wdata[i*WORD_LANE_W +: WORD_LANE_W] = {i_parity_lanes[i] & parity_on,
                                                       i_dq[i*LANE_W +: LANE_W]};
        end
    end

    sbsc_mem u_mem (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_addr(mem_addr),
        .i_lane_we(mem_we),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            op_q <= OP_IDLE;
        end else begin
            case (cmd)
                CMD_DESEL: op_q <= OP_DESEL;
                CMD_LOAD_RD: op_q <= OP_READ;
                CMD_LOAD_WR: op_q <= OP_WRITE;
                CMD_STEP, CMD_HOLD: op_q <= wr_dec ? OP_WRITE : OP_READ;
                default: op_q <= OP_IDLE;
            endcase
        end
    end

    // Output register stage used only in pipelined mode
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_q2 <= 1'b0;
            pipe_word <= WORD_RST;
        end else begin
            rd_q2 <= (op_q == OP_READ);
            pipe_word <= mem_rdata;
        end
    end

    assign out_word = pipe_mode ? pipe_word : mem_rdata;

    // Writes and deselects cut the drivers; dual deselect waits for rd_q2
    always_comb begin
        if (pipe_mode) begin
            drive = rd_q2 && (op_q != OP_WRITE) && !(single_desel && op_q == OP_DESEL);
        end else begin
            drive = (op_q == OP_READ);
        end
    end

    // Asynchronous gates: output enable and sleep act without a clock
    assign o_dq_oe = (drive && !i_out_enable_n && !sleep) ? LANES_ALL : LANES_NONE;
    assign o_parity_lanes_oe = parity_on ? o_dq_oe : LANES_NONE;

    always_comb begin
        for (int i = 0; i < LANE_CNT; i++) begin
            o_dq[i*LANE_W +: LANE_W] = out_word[i*WORD_LANE_W +: LANE_W];
            o_parity_lanes[i] = out_word[i*WORD_LANE_W + LANE_W];
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    a_burst_wrap: assert property (
        (cmd == CMD_LOAD_RD || cmd == CMD_LOAD_WR) ##1 (cmd == CMD_STEP) [*4] |=> cnt == CNT_ZERO)
        else $error("burst counter did not wrap after four steps");

    a_interleave_order: assert property (
        cmd == CMD_STEP && !linear |-> mem_addr[CNT_W-1:0] == (base_addr[CNT_W-1:0] ^ next_cnt))
        else $error("interleaved burst address wrong");

    a_float_defaults: assert property (
        i_mode_float[MF_FT] && i_mode_float[MF_SCD] |-> pipe_mode && single_desel)
        else $error("open mode pins not pulled high");

    a_sleep_default: assert property (
        i_mode_float[MF_ZZ] && i_mode_float[MF_PE] |-> !o_standby && parity_on)
        else $error("open sleep or parity pin not pulled low");

    a_read_no_write: assert property (
        i_global_write_n && i_byte_write_n |-> mem_we == LANES_NONE)
        else $error("lane written during read cycle");

    a_global_write: assert property (
        cmd == CMD_LOAD_WR && !i_global_write_n |-> mem_we == LANES_ALL)
        else $error("global write missed a lane");

    a_write_hiz: assert property (
        cmd == CMD_LOAD_WR |=> o_dq_oe == LANES_NONE)
        else $error("data lanes driven during write");

    // Flow-through shows the deselect one clock sooner than the dual-deselect pipeline
    a_partial_desel: assert property (
        !sleep && !i_cpu_addr_strobe_n && !i_chip_sel1_n && !chip_en |=>
        op_q == OP_DESEL && (pipe_mode || o_dq_oe == LANES_NONE) ##1
        (!pipe_mode || o_dq_oe == LANES_NONE))
        else $error("partial enable did not deselect");

    a_cpu_load: assert property (
        !sleep && !i_cpu_addr_strobe_n && chip_en |=>
        base_addr == $past(i_addr) && cnt == CNT_ZERO && op_q == OP_READ)
        else $error("processor strobe load wrong");

    a_ctrl_load: assert property (
        !sleep && i_cpu_addr_strobe_n && !i_cache_ctrl_addr_strobe_n && chip_en && wr_dec |=>
        op_q == OP_WRITE && base_addr == $past(i_addr))
        else $error("controller strobe write load wrong");

    a_ctrl_desel: assert property (
        !sleep && i_cpu_addr_strobe_n && !i_cache_ctrl_addr_strobe_n && !chip_en |=>
        op_q == OP_DESEL)
        else $error("controller strobe without enable did not deselect");

    a_byte_lanes: assert property (
        cmd == CMD_LOAD_WR && i_global_write_n |->
        mem_we == ~{i_lane3_write_n, i_lane2_write_n, i_lane1_write_n, i_lane0_write_n})
        else $error("byte write lanes wrong");

    a_step_advance: assert property (
        cmd == CMD_STEP |=> cnt == CNT_W'($past(cnt) + CNT_ONE) && $stable(base_addr))
        else $error("advance did not step the counter");

    a_suspend_hold: assert property (
        cmd == CMD_HOLD |=> $stable(cnt) && $stable(base_addr))
        else $error("suspend changed the address");

    a_oe_gate: assert property (
        i_out_enable_n || sleep |-> o_dq_oe == LANES_NONE)
        else $error("drivers on with output enable high");

    a_pipe_latency: assert property (
        pipe_mode && $past(pipe_mode) && rd_q2 |-> out_word == $past(mem_rdata))
        else $error("pipelined data not delayed one clock");

    a_scd_early_off: assert property (
        pipe_mode && single_desel && op_q == OP_DESEL |-> o_dq_oe == LANES_NONE)
        else $error("single deselect left drivers on");

    c_read_burst: cover property (
        cmd == CMD_LOAD_RD ##1 (cmd == CMD_STEP) [*3] ##1 o_dq_oe == LANES_ALL);
    c_byte_write: cover property (
        cmd == CMD_LOAD_WR && i_global_write_n && mem_we != LANES_ALL);
    c_dummy_read: cover property (
        op_q == OP_READ && i_out_enable_n ##1 op_q == OP_WRITE);
    c_dcd_tail: cover property (
        pipe_mode && !single_desel && op_q == OP_DESEL && o_dq_oe == LANES_ALL);
endmodule : sbsc_ctrl

// ---- dv/sbsc_host.sv ----
`timescale 1ns/1ps
module sbsc_host
    import sbsc_pkg::*;
(
    input wire logic i_sys_clk, // Bus clock
    output logic [2:0] o_sel, // Selects 1_n, 2, 3_n
    output logic o_cpu_n, // Processor strobe
    output logic o_ctl_n, // Controller strobe
    output logic o_step_n, // Advance
    output logic o_gw_n, // Global write
    output logic o_bw_n, // Byte write
    output logic [sbsc_pkg::LANE_CNT-1:0] o_lane_n, // Lane writes
    output logic [sbsc_pkg::ADDR_W-1:0] o_addr, // Address
    output logic [sbsc_pkg::DATA_W-1:0] o_dq, // Write data
    output logic [sbsc_pkg::LANE_CNT-1:0] o_par // Ninth bits
);
    function automatic logic [3:0] par_of(input logic [31:0] d);
        for (int i = 0; i < 4; i++) begin
            par_of[i] = ^d[8*i+:8];
        end
    endfunction : par_of

    task automatic put(input logic [2:0] s, input logic p, c, v, g, b,
                       input logic [3:0] ln, input logic [17:0] a, input logic [31:0] d);
        o_sel = s;
        o_cpu_n = p;
        o_ctl_n = c;
        o_step_n = v;
        o_gw_n = g;
        o_bw_n = b;
        o_lane_n = ln;
        o_addr = a;
        // Undriven data lines flip, so a stale copy can never pass for data
        o_dq = (g & b) ? ~o_dq : d;
        o_par = par_of(o_dq);
    endtask : put

    // Moves only at the falling edge, held across the sampling edge
    task automatic cmd(input logic [2:0] s, input logic p, c, v, g, b,
                       input logic [3:0] ln, input logic [17:0] a, input logic [31:0] d);
        @(negedge i_sys_clk);
        put(s, p, c, v, g, b, ln, a, d);
    endtask : cmd

    task automatic ld(input logic [17:0] a, input logic g, b, input logic [3:0] ln,
                      input logic [31:0] d);
        cmd(3'h2, 1'h1, 1'h0, 1'h1, g, b, ln, a, d);
    endtask : ld

    task automatic rd_cpu(input logic [17:0] a);
        // Write inputs asserted on purpose: they must be ignored here
        cmd(3'h2, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 4'h0, a, 32'h0000_0000);
    endtask : rd_cpu

    task automatic nx(input logic v, g, input logic [31:0] d);
        cmd(3'h2, 1'h1, 1'h1, v, g, 1'h1, 4'hF, 18'h0_0000, d);
    endtask : nx

    task automatic des();
        cmd(3'h6, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'hF, 18'h0_0000, 32'h0000_0000);
    endtask : des

    initial begin
        o_dq = 32'h0000_0000;
        put(3'h6, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'hF, 18'h0_0000, 32'h0000_0000);
    end
endmodule : sbsc_host

// ---- dv/tb_sbsc_ctrl.sv ----
`timescale 1ns/1ps
module tb_sbsc_ctrl;
    import sbsc_pkg::*;
    logic clk, rst_n, oe_n, order_n, flow_n, deselect_depth_select, ds, sleep, pe_n, hd, sb;
    logic cpu_n, ctl_n, step_n, gw_n, bw_n;
    logic [2:0] sel;
    logic [3:0] lane_n, par_in, par, par_oe, dq_oe;
    logic [4:0] flt;
    logic [17:0] addr;
    logic [31:0] dq_in, dq;
    logic [31:0] mdat [logic [17:0]];
    int failures, checked;

    sbsc_ctrl i_sbsc_ctrl (.i_sys_clk(clk), .i_arst_n(rst_n), .i_addr(addr),
        .i_dq(dq_in), .o_dq(dq), .o_dq_oe(dq_oe), .i_parity_lanes(par_in),
        .o_parity_lanes(par), .o_parity_lanes_oe(par_oe), .i_chip_sel1_n(sel[2]),
        .i_chip_sel2(sel[1]), .i_chip_sel3_n(sel[0]), .i_cpu_addr_strobe_n(cpu_n),
        .i_cache_ctrl_addr_strobe_n(ctl_n), .i_burst_step_n(step_n),
        .i_global_write_n(gw_n), .i_byte_write_n(bw_n), .i_lane0_write_n(lane_n[0]),
        .i_lane1_write_n(lane_n[1]), .i_lane2_write_n(lane_n[2]),
        .i_lane3_write_n(lane_n[3]), .i_out_enable_n(oe_n),
        .i_burst_order_select_n(order_n), .i_flow_through_select_n(flow_n),
        .i_deselect_depth_select(deselect_depth_select), .i_drive_strength_select(ds),
        .i_sleep_request(sleep), .i_parity_lane_enable_n(pe_n), .i_mode_float(flt),
        .o_high_drive(hd), .o_standby(sb));

    sbsc_host i_sbsc_host (.i_sys_clk(clk), .o_sel(sel), .o_cpu_n(cpu_n), .o_ctl_n(ctl_n),
        .o_step_n(step_n), .o_gw_n(gw_n), .o_bw_n(bw_n), .o_lane_n(lane_n),
        .o_addr(addr), .o_dq(dq_in), .o_par(par_in));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [17:0] baddr(input logic [17:0] a, input int k, input logic ilv);
        logic [1:0] lo;
        lo = ilv ? (a[1:0] ^ 2'(k)) : 2'(a[1:0] + 2'(k));
        return {a[17:2], lo};
    endfunction : baddr

    task automatic rd_ok(input logic [17:0] ea);
        chk("read word", {i_sbsc_host.par_of(mdat[ea]), mdat[ea]}, {par, dq});
        chk("lane drive", 36'(LANES_ALL), 36'(dq_oe));
        chk("ninth drive", 36'(LANES_ALL), 36'(par_oe));
    endtask : rd_ok

    task automatic t_modes();
        flt = 5'h1F;
        // Held across an edge so the open-pin assertions see it
        @(negedge clk);
        chk("drive open", 36'h0_0000_0000, 36'(hd));
        chk("sleep open", 36'h0_0000_0000, 36'(sb));
        flt = 5'h00;
        ds = 1'h0;
        #1;
        chk("drive low", 36'h0_0000_0001, 36'(hd));
        chk("sleep high", 36'h0_0000_0001, 36'(sb));
        ds = 1'h1;
        sleep = 1'h0;
        // Flow pin low but open, parity pin high but open: defaults must win
        flt = 5'h11;
        $display("modes done");
    endtask : t_modes

    task automatic t_wburst(input logic [17:0] a, input logic ilv);
        logic [17:0] ea;
        order_n = ilv;
        for (int k = 0; k < 4; k++) begin
            ea = baddr(a, k, ilv);
            mdat[ea] = {~ea[15:0], ea[15:0]};
            if (k == 0) i_sbsc_host.ld(a, 1'h0, 1'h1, 4'hF, mdat[ea]);
            else i_sbsc_host.nx(1'h0, 1'h0, mdat[ea]);
            chk("write drive", 36'h0_0000_0000, 36'(dq_oe));
        end
        i_sbsc_host.des();
        $display("write burst done");
    endtask : t_wburst

    task automatic t_rburst(input logic [17:0] a, input logic ilv, input int lag);
        order_n = ilv;
        for (int k = 0; k < 5 + lag; k++) begin
            if (k == 0) i_sbsc_host.rd_cpu(a);
            else i_sbsc_host.nx(k >= 5, 1'h1, 32'h0000_0000);
            if (k >= lag) rd_ok(baddr(a, k - lag, ilv));
        end
        i_sbsc_host.des();
        $display("read burst done");
    endtask : t_rburst

    task automatic t_bytes();
        logic [17:0] a;
        a = 18'h0_0300;
        order_n = 1'h0;
        i_sbsc_host.ld(a, 1'h0, 1'h0, 4'hE, 32'h1122_3344);
        i_sbsc_host.ld(a, 1'h1, 1'h0, 4'hA, 32'hAABB_CCDD);
        i_sbsc_host.ld(a, 1'h1, 1'h0, 4'hF, 32'hFFFF_FFFF);
        i_sbsc_host.ld(a, 1'h1, 1'h1, 4'h0, 32'h0000_0000);
        mdat[a] = 32'h11BB_33DD;
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        rd_ok(a);
        i_sbsc_host.des();
        $display("byte lanes done");
    endtask : t_bytes

    task automatic t_hold();
        order_n = 1'h0;
        i_sbsc_host.ld(18'h0_0104, 1'h1, 1'h1, 4'hF, 32'h0000_0000);
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        rd_ok(18'h0_0104);
        i_sbsc_host.nx(1'h0, 1'h1, 32'h0000_0000);
        rd_ok(18'h0_0104);
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        rd_ok(18'h0_0104);
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        rd_ok(18'h0_0105);
        i_sbsc_host.des();
        $display("hold done");
    endtask : t_hold

    task automatic t_desel(input logic s, input logic [2:0] sc, input logic ctl);
        deselect_depth_select = s;
        order_n = 1'h0;
        i_sbsc_host.ld(18'h0_0104, 1'h1, 1'h1, 4'hF, 32'h0000_0000);
        i_sbsc_host.cmd(sc, ctl, ~ctl, 1'h1, 1'h1, 1'h1, 4'hF, 18'h0_0208, 32'h0000_0000);
        i_sbsc_host.des();
        if (s) chk("single off", 36'h0_0000_0000, 36'(dq_oe));
        else rd_ok(18'h0_0104);
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        chk("dual off", 36'h0_0000_0000, 36'(dq_oe));
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        // Hold read after the deselect shows one clock later in pipeline
        i_sbsc_host.nx(1'h1, 1'h1, 32'h0000_0000);
        rd_ok(18'h0_0104);
        i_sbsc_host.des();
        deselect_depth_select = 1'h1;
        $display("deselect done");
    endtask : t_desel

    task automatic t_oe();
        logic [17:0] a;
        a = 18'h0_0208;
        order_n = 1'h1;
        oe_n = 1'h1;
        i_sbsc_host.rd_cpu(a);
        i_sbsc_host.nx(1'h0, 1'h1, 32'h0000_0000);
        i_sbsc_host.nx(1'h0, 1'h1, 32'h0000_0000);
        chk("gated drive", 36'h0_0000_0000, 36'(dq_oe));
        oe_n = 1'h0;
        #1;
        rd_ok(a);
        flt = 5'h01;
        #1;
        chk("ninth off", 36'h0_0000_0000, 36'(par_oe));
        flt = 5'h11;
        i_sbsc_host.nx(1'h0, 1'h1, 32'h0000_0000);
        rd_ok(baddr(a, 1, 1'h1));
        oe_n = 1'h1;
        #1;
        chk("async off", 36'h0_0000_0000, 36'(dq_oe));
        mdat[a] = 32'h5A5A_0F0F;
        i_sbsc_host.ld(a, 1'h0, 1'h1, 4'hF, mdat[a]);
        i_sbsc_host.des();
        oe_n = 1'h0;
        #1;
        chk("after write", 36'h0_0000_0000, 36'(dq_oe));
        i_sbsc_host.rd_cpu(a);
        i_sbsc_host.nx(1'h0, 1'h1, 32'h0000_0000);
        i_sbsc_host.nx(1'h0, 1'h1, 32'h0000_0000);
        rd_ok(a);
        i_sbsc_host.des();
        $display("output enable done");
    endtask : t_oe

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    initial begin
        #(3000 * 100);
        failures++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        failures = 0;
        checked = 0;
        rst_n = 1'h0;
        oe_n = 1'h0;
        order_n = 1'h0;
        flow_n = 1'h0;
        deselect_depth_select = 1'h1;
        ds = 1'h1;
        sleep = 1'h1;
        pe_n = 1'h1;
        flt = 5'h11;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'h1;
        t_modes();
        t_wburst(18'h0_0104, 1'h0);
        t_rburst(18'h0_0106, 1'h0, 2);
        t_wburst(18'h0_0208, 1'h1);
        t_rburst(18'h0_020B, 1'h1, 2);
        flt = 5'h10;
        t_rburst(18'h0_0105, 1'h0, 1);
        flt = 5'h11;
        t_bytes();
        t_hold();
        t_desel(1'h1, 3'h0, 1'h0);
        t_desel(1'h0, 3'h3, 1'h0);
        t_desel(1'h1, 3'h6, 1'h1);
        t_oe();
        conclude();
    end
endmodule : tb_sbsc_ctrl
